// ---- rtl/aer_regs_pkg.sv ----
`default_nettype none
package aer_regs_pkg;
  // byte addresses of the register words
  localparam logic [11:0] CORR_FLAGS_ADDR = 12'h110;
  localparam logic [11:0] CORR_MASKS_ADDR = 12'h114;
  localparam logic [11:0] CAP_CTRL_ADDR = 12'h118;
  localparam logic [11:0] HDR_WORD0_ADDR = 12'h11c;
  localparam logic [11:0] HDR_WORD1_ADDR = 12'h120;
  localparam logic [11:0] HDR_WORD2_ADDR = 12'h124;
  localparam logic [11:0] HDR_WORD3_ADDR = 12'h128;
  localparam logic [11:0] INT_FLAGS_ADDR = 12'h130;
  localparam logic [11:0] INT_MASK_ADDR = 12'h134;

  // correctable status / mask bit positions
  localparam int RX_ERR_BIT = 0;
  localparam int BAD_TLP_BIT = 6;
  localparam int BAD_DLLP_BIT = 7;
  localparam int REPLAY_ROLL_BIT = 8;
  localparam int REPLAY_TMO_BIT = 12;
  localparam int ADVISORY_BIT = 13;
  localparam logic [31:0] CORR_VALID_MASK = 32'h0000_31c1;
  localparam logic [31:0] CORR_RESET = 32'h0000_0000;

  // capability / control field positions
  localparam int FEP_LSB = 0;
  localparam int FEP_MSB = 4;
  localparam int GEN_CAP_BIT = 5;
  localparam int GEN_EN_BIT = 6;
  localparam int CHK_CAP_BIT = 7;
  localparam int CHK_EN_BIT = 8;
  localparam logic [31:0] HDR_RESET = 32'h0000_0000;

  // interrupt status bits: one shared by all unmasked correctable errors, one for header capture
  localparam int INT_CORR_BIT = 0;
  localparam int INT_HDR_BIT = 1;
  localparam int INT_WIDTH = 2;
endpackage
`default_nettype wire

// ---- rtl/aer_w1c_bit.sv ----
`default_nettype none
module aer_w1c_bit (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // set and clear
  input wire logic set_in,
  input wire logic clr_in,
  // state
  output logic flag_out
);
  typedef struct packed {
    logic flag;
  } w1c_state_t;
  w1c_state_t st_r;
  w1c_state_t st_nxt;

  // a set in the cycle of a clear wins so no event is lost
  always_comb begin
    st_nxt = st_r;
    if (clr_in) begin
      st_nxt.flag = 1'b0;
    end
    if (set_in) begin
      st_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_out = st_r.flag;

  a_set_wins: assert property (@(posedge clk_in) disable iff (reset_in)
    set_in |=> flag_out) else $error("flag not set after event");
endmodule
`default_nettype wire

// ---- rtl/aer_hdr_word.sv ----
`default_nettype none
module aer_hdr_word
  import aer_regs_pkg::*;
(
  // clock and cold reset only: the word is sticky
  input wire logic clk_in,
  input wire logic cold_reset_in,
  // capture
  input wire logic load_in,
  input wire logic [31:0] data_in,
  // stored word
  output logic [31:0] word_out
);
  typedef struct packed {
    logic [31:0] word;
  } hdr_state_t;
  hdr_state_t st_r;
  hdr_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (load_in) begin
      st_nxt.word = data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (cold_reset_in) begin
      st_r.word <= HDR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word_out = st_r.word;
endmodule
`default_nettype wire

// ---- rtl/aer_regs.sv ----
`default_nettype none
// Overview of operation
// - a receiver error sets status bit 0, reset zero, cleared by writing one.
// - a bad transaction layer packet sets status bit 6, cleared by writing one.
// - a bad data link layer packet sets status bit 7, cleared by writing one.
// - a replay number rollover sets status bit 8, cleared by writing one.
// - a replay timer expiry sets status bit 12, cleared by writing one.
// - an advisory non-fatal error sets status bit 13, cleared by writing one.
// - the mask word has a read-write bit reset to zero at each status bit.
// - mask bits sit at 0, 6, 7, 8, 12 and 13 matching the status layout.
// - an uncorrectable error captures the packet header into the log words.
// - header byte 0 lands in bits 31:24 of the first captured log word.
// - log words are 32-bit, read-only, sticky, and zero after cold reset.
module aer_regs
  import aer_regs_pkg::*;
#(
  parameter logic ECRC_GEN_CAPABLE = 1'b1,
  parameter logic ECRC_CHK_CAPABLE = 1'b1
) (
  // clock and resets
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic COLD_RESET_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // correctable error events, one-cycle pulses
  input wire logic RX_ERR_IN,
  input wire logic BAD_TLP_IN,
  input wire logic BAD_DLLP_IN,
  input wire logic REPLAY_ROLL_IN,
  input wire logic REPLAY_TMO_IN,
  input wire logic ADVISORY_IN,
  // uncorrectable error capture
  input wire logic UNCORR_ERR_IN,
  input wire logic [4:0] UNCORR_POS_IN,
  input wire logic [127:0] HDR_IN,
  // outputs
  output logic ECRC_GEN_EN_OUT,
  output logic ECRC_CHK_EN_OUT,
  output logic CORR_REPORT_OUT,
  output logic IRQ_OUT
);
  typedef struct packed {
    logic [31:0] masks;
    logic [4:0] first_ptr;
    logic fep_valid;
    logic gen_en;
    logic chk_en;
    logic [INT_WIDTH-1:0] int_mask;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic gen_out;
    logic chk_out;
    logic corr_rep;
    logic irq;
  } regs_state_t;
  regs_state_t st_r;
  regs_state_t st_nxt;

  // sticky part survives ordinary reset
  typedef struct packed {
    logic [4:0] ptr;
    logic valid;
  } sticky_t;
  sticky_t sk_r;
  sticky_t sk_nxt;

  logic access;
  logic wr;
  logic [31:0] ev;
  logic [31:0] clr;
  logic [31:0] flags;
  logic [INT_WIDTH-1:0] int_ev;
  logic [INT_WIDTH-1:0] int_clr;
  logic [INT_WIDTH-1:0] int_flags;
  logic [31:0] hdr_word [4];
  logic [31:0] cap_word;
  logic hit;

  // one wait state: pready is registered and rises the cycle after the access cycle
  assign access = PSEL_IN && PENABLE_IN && !st_r.ready;
  assign wr = access && PWRITE_IN;

  always_comb begin
    ev = '0;
    ev[RX_ERR_BIT] = RX_ERR_IN;
    ev[BAD_TLP_BIT] = BAD_TLP_IN;
    ev[BAD_DLLP_BIT] = BAD_DLLP_IN;
    ev[REPLAY_ROLL_BIT] = REPLAY_ROLL_IN;
    ev[REPLAY_TMO_BIT] = REPLAY_TMO_IN;
    ev[ADVISORY_BIT] = ADVISORY_IN;
  end

  // only defined positions accept a write-one clear
  assign clr = (wr && PADDR_IN == CORR_FLAGS_ADDR) ?
               (PWDATA_IN & CORR_VALID_MASK) : 32'h0000_0000;

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_flag
      if (CORR_VALID_MASK[g]) begin : g_impl
        aer_w1c_bit u_bit (
          .clk_in(CLK_SYS_IN),
          .reset_in(RESET_IN),
          .set_in(ev[g]),
          .clr_in(clr[g]),
          .flag_out(flags[g])
        );
      end else begin : g_rsvd
        assign flags[g] = 1'b0;
      end
    end
    for (g = 0; g < 4; g++) begin : g_hdr
      // byte 0 of the header is the top byte of HDR_IN
      aer_hdr_word u_word (
        .clk_in(CLK_SYS_IN),
        .cold_reset_in(COLD_RESET_IN),
        .load_in(UNCORR_ERR_IN),
        .data_in(HDR_IN[127-32*g -: 32]),
        .word_out(hdr_word[g])
      );
    end
  endgenerate

  assign int_ev[INT_CORR_BIT] = |(ev & ~st_r.masks);
  assign int_ev[INT_HDR_BIT] = UNCORR_ERR_IN;
  assign int_clr = (wr && PADDR_IN == INT_FLAGS_ADDR) ?
                   PWDATA_IN[INT_WIDTH-1:0] : '0;
  generate
    for (g = 0; g < INT_WIDTH; g++) begin : g_int
      aer_w1c_bit u_int (
        .clk_in(CLK_SYS_IN),
        .reset_in(RESET_IN),
        .set_in(int_ev[g]),
        .clr_in(int_clr[g]),
        .flag_out(int_flags[g])
      );
    end
  endgenerate

  always_comb begin
    cap_word = '0;
    cap_word[FEP_MSB:FEP_LSB] = sk_r.ptr;
    cap_word[GEN_CAP_BIT] = ECRC_GEN_CAPABLE;
    cap_word[GEN_EN_BIT] = st_r.gen_en;
    cap_word[CHK_CAP_BIT] = ECRC_CHK_CAPABLE;
    cap_word[CHK_EN_BIT] = st_r.chk_en;
  end

  always_comb begin
    sk_nxt = sk_r;
    // pointer holds the first error until the log is re-armed
    if (UNCORR_ERR_IN && !sk_r.valid) begin
      sk_nxt.ptr = UNCORR_POS_IN;
      sk_nxt.valid = 1'b1;
    end
    if (int_clr[INT_HDR_BIT] && !UNCORR_ERR_IN) begin
      sk_nxt.valid = 1'b0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    hit = 1'b1;
    st_nxt.ready = access;
    st_nxt.slverr = 1'b0;
    if (access) begin
      st_nxt.rdata = 32'h0000_0000;
      unique case (PADDR_IN)
        CORR_FLAGS_ADDR: st_nxt.rdata = flags;
        CORR_MASKS_ADDR: begin
          st_nxt.rdata = st_r.masks;
          if (PWRITE_IN) begin
            st_nxt.masks = PWDATA_IN & CORR_VALID_MASK;
          end
        end
        CAP_CTRL_ADDR: begin
          st_nxt.rdata = cap_word;
          if (PWRITE_IN) begin
            st_nxt.gen_en = PWDATA_IN[GEN_EN_BIT];
            st_nxt.chk_en = PWDATA_IN[CHK_EN_BIT];
          end
        end
        HDR_WORD0_ADDR: st_nxt.rdata = hdr_word[0];
        HDR_WORD1_ADDR: st_nxt.rdata = hdr_word[1];
        HDR_WORD2_ADDR: st_nxt.rdata = hdr_word[2];
        HDR_WORD3_ADDR: st_nxt.rdata = hdr_word[3];
        INT_FLAGS_ADDR: st_nxt.rdata = {30'h0, int_flags};
        INT_MASK_ADDR: begin
          st_nxt.rdata = {30'h0, st_r.int_mask};
          if (PWRITE_IN) begin
            st_nxt.int_mask = PWDATA_IN[INT_WIDTH-1:0];
          end
        end
        default: hit = 1'b0;
      endcase
      st_nxt.slverr = !hit;
    end
    // an enable only acts when the matching capability is present
    st_nxt.gen_out = st_nxt.gen_en && ECRC_GEN_CAPABLE;
    st_nxt.chk_out = st_nxt.chk_en && ECRC_CHK_CAPABLE;
    st_nxt.corr_rep = |(ev & ~st_r.masks);
    st_nxt.irq = |(int_flags & ~st_r.int_mask);
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (COLD_RESET_IN) begin
      sk_r <= '0;
    end else begin
      sk_r <= sk_nxt;
    end
  end

  assign PRDATA_OUT = st_r.rdata;
  assign PREADY_OUT = st_r.ready;
  assign PSLVERR_OUT = st_r.slverr;
  assign ECRC_GEN_EN_OUT = st_r.gen_out;
  assign ECRC_CHK_EN_OUT = st_r.chk_out;
  assign CORR_REPORT_OUT = st_r.corr_rep;
  assign IRQ_OUT = st_r.irq;

  // a one-edge cold reset leaves disable iff at that very edge, so the
  // sticky checks also test the sampled cold reset in their antecedent
  a_rx_err_set: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    RX_ERR_IN |=> flags[RX_ERR_BIT]) else $error("rx error not set");
  a_rx_clear: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    clr[RX_ERR_BIT] && !RX_ERR_IN |=> !flags[RX_ERR_BIT])
    else $error("rx error not cleared");
  a_bad_tlp_set: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    BAD_TLP_IN |=> flags[BAD_TLP_BIT]) else $error("bad tlp not set");
  a_bad_dllp_set: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    BAD_DLLP_IN |=> flags[BAD_DLLP_BIT]) else $error("dllp not set");
  a_roll_set: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    REPLAY_ROLL_IN |=> flags[REPLAY_ROLL_BIT]) else $error("roll");
  a_tmo_set: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    REPLAY_TMO_IN |=> flags[REPLAY_TMO_BIT]) else $error("timeout");
  a_adv_clear: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    clr[ADVISORY_BIT] && !ADVISORY_IN |=> !flags[ADVISORY_BIT])
    else $error("advisory not cleared");
  a_adv_set: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ADVISORY_IN |=> flags[ADVISORY_BIT]) else $error("advisory not set");
  a_mask_report: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    st_r.masks[RX_ERR_BIT] && $stable(st_r.masks) && ev == 32'h1
    |=> !CORR_REPORT_OUT) else $error("masked error reported");
  a_unmasked_report: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    |(ev & ~st_r.masks) |=> CORR_REPORT_OUT)
    else $error("unmasked error not reported");
  a_mask_layout: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (st_r.masks & ~CORR_VALID_MASK) == 32'h0)
    else $error("mask outside layout");
  a_hdr_capture: assert property (
    @(posedge CLK_SYS_IN) disable iff (COLD_RESET_IN)
    UNCORR_ERR_IN |=> hdr_word[0] == $past(HDR_IN[127:96]))
    else $error("header not captured");
  a_hdr_last_word: assert property (
    @(posedge CLK_SYS_IN) disable iff (COLD_RESET_IN)
    UNCORR_ERR_IN |=> hdr_word[3] == $past(HDR_IN[31:0]))
    else $error("last header word not captured");
  a_hdr_sticky: assert property (
    @(posedge CLK_SYS_IN) disable iff (COLD_RESET_IN)
    !COLD_RESET_IN && !UNCORR_ERR_IN |=> $stable(hdr_word[3]))
    else $error("header word changed");
  a_fep_first: assert property (
    @(posedge CLK_SYS_IN) disable iff (COLD_RESET_IN)
    UNCORR_ERR_IN && !sk_r.valid |=> sk_r.ptr == $past(UNCORR_POS_IN))
    else $error("first pointer not recorded");
  a_fep_hold: assert property (
    @(posedge CLK_SYS_IN) disable iff (COLD_RESET_IN)
    !COLD_RESET_IN && sk_r.valid && !int_clr[INT_HDR_BIT]
    |=> $stable(sk_r.ptr)) else $error("first pointer moved");
  a_ecrc_gated: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ECRC_GEN_EN_OUT == (st_r.gen_en && ECRC_GEN_CAPABLE) &&
    ECRC_CHK_EN_OUT == (st_r.chk_en && ECRC_CHK_CAPABLE))
    else $error("ecrc enable not gated");
  a_rsvd_zero: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (flags & ~CORR_VALID_MASK) == 32'h0) else $error("reserved set");
  a_ready_pulse: assert property (
    @(posedge CLK_SYS_IN) disable iff (RESET_IN)
    PREADY_OUT |=> !PREADY_OUT) else $error("ready held too long");
  c_clear_flag: cover property (@(posedge CLK_SYS_IN) clr[RX_ERR_BIT]);
  c_hdr_log: cover property (@(posedge CLK_SYS_IN) UNCORR_ERR_IN);
  c_irq: cover property (@(posedge CLK_SYS_IN) IRQ_OUT);
  c_masked_event: cover property (@(posedge CLK_SYS_IN)
    |(ev & st_r.masks));
  c_ptr_recorded: cover property (@(posedge CLK_SYS_IN)
    UNCORR_ERR_IN && !sk_r.valid);
endmodule
`default_nettype wire

// ---- bench/link_partner.sv ----
`default_nettype none
module link_partner (
  // clock
  input wire logic clk_in,
  // requests from the bench
  input wire logic [5:0] ev_req_in,
  input wire logic cap_req_in,
  input wire logic [4:0] pos_req_in,
  input wire logic [127:0] hdr_req_in,
  // link-side lines
  output logic [5:0] ev_out = '0,
  output logic cap_out = 1'b0,
  output logic [4:0] pos_out = '0,
  output logic [127:0] hdr_out = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  // header lines mean nothing outside a capture: scramble them so a
  // design that samples at the wrong edge cannot get lucky
  always @(posedge clk_in) begin
    ev_out <= ev_req_in;
    cap_out <= cap_req_in;
    pos_out <= cap_req_in ? pos_req_in : ~pos_out;
    hdr_out <= cap_req_in ? hdr_req_in : ~hdr_out;
  end
endmodule
`default_nettype wire

// ---- bench/tb_advanced_error_report_regs.sv ----
`default_nettype none
module tb_advanced_error_report_regs
  import aer_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, cold = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, m;
  logic pready, pslverr, gen_en, chk_en, rep, irq, uerr, er;
  logic cap_req = 0;
  logic [5:0] ev, ev_req = '0;
  logic [4:0] upos, pos_req = '0, p1;
  logic [127:0] hdr, hdr_req = '0;
  int err_total = 0, total_checks = 0, rep_cnt = 0, seed = 32'ha61ba4fe;
  int bitpos [6] = '{RX_ERR_BIT, BAD_TLP_BIT, BAD_DLLP_BIT,
    REPLAY_ROLL_BIT, REPLAY_TMO_BIT, ADVISORY_BIT};
  logic [11:0] addrs [9] = '{CORR_FLAGS_ADDR, CORR_MASKS_ADDR,
    CAP_CTRL_ADDR, HDR_WORD0_ADDR, HDR_WORD1_ADDR, HDR_WORD2_ADDR,
    HDR_WORD3_ADDR, INT_FLAGS_ADDR, INT_MASK_ADDR};

  aer_regs aer_regs_inst (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .COLD_RESET_IN(cold),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .RX_ERR_IN(ev[0]), .BAD_TLP_IN(ev[1]), .BAD_DLLP_IN(ev[2]),
    .REPLAY_ROLL_IN(ev[3]), .REPLAY_TMO_IN(ev[4]), .ADVISORY_IN(ev[5]),
    .UNCORR_ERR_IN(uerr), .UNCORR_POS_IN(upos), .HDR_IN(hdr),
    .ECRC_GEN_EN_OUT(gen_en), .ECRC_CHK_EN_OUT(chk_en),
    .CORR_REPORT_OUT(rep), .IRQ_OUT(irq));

  link_partner link_partner_inst (
    .clk_in(clk), .ev_req_in(ev_req), .cap_req_in(cap_req),
    .pos_req_in(pos_req), .hdr_req_in(hdr_req), .ev_out(ev),
    .cap_out(uerr), .pos_out(upos), .hdr_out(hdr));

  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (rep === 1'b1) rep_cnt++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // no wait-state count is assumed: only the bound cuts a hang
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    rd = prdata;
    er = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic pulse(input logic [5:0] e, input logic c);
    @(posedge clk);
    ev_req <= e;
    cap_req <= c;
    @(posedge clk);
    ev_req <= '0;
    cap_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] hword(input logic [127:0] h, input int k);
    return h[127-32*k -: 32];
  endfunction

  // both capable parameters are left at one in this bench
  function automatic logic [31:0] ctrl_exp(input logic [4:0] p,
    input logic g, input logic c);
    return {23'h0, c, 1'b1, g, 1'b1, p};
  endfunction

  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict;
  end

  initial begin
    int n;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cold <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rdchk(addrs[i], i == 2 ? ctrl_exp(5'h0, 0, 0) : 32'h0);
    end
    apb(1'b1, 12'h200, 32'hffffffff);
    chk({31'h0, er}, 32'h1);
    rdchk(12'h200, 32'h0);
    chk({31'h0, er}, 32'h1);
    for (int i = 0; i < 6; i++) begin
      m = $random(seed);
      apb(1'b1, CORR_MASKS_ADDR, m);
      rdchk(CORR_MASKS_ADDR, m & CORR_VALID_MASK);
      n = rep_cnt;
      pulse(6'h1 << i, 1'b0);
      chk(32'(rep_cnt - n), {31'h0, ~m[bitpos[i]]});
      rdchk(CORR_FLAGS_ADDR, 32'h1 << bitpos[i]);
      apb(1'b1, CORR_FLAGS_ADDR, 32'hffffffff);
      rdchk(CORR_FLAGS_ADDR, 32'h0);
    end
    pulse(6'h3f, 1'b0);
    apb(1'b1, CORR_FLAGS_ADDR, 32'h1);
    rdchk(CORR_FLAGS_ADDR, CORR_VALID_MASK & ~32'h1);
    apb(1'b1, INT_FLAGS_ADDR, 32'h3);
    rdchk(INT_FLAGS_ADDR, 32'h0);
    apb(1'b1, CAP_CTRL_ADDR, 32'hffffffff);
    rdchk(CAP_CTRL_ADDR, ctrl_exp(5'h0, 1, 1));
    chk({30'h0, gen_en, chk_en}, 32'h3);
    apb(1'b1, CAP_CTRL_ADDR, 32'h0);
    chk({30'h0, gen_en, chk_en}, 32'h0);
    hdr_req <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    p1 = 5'($random(seed));
    pos_req <= p1;
    pulse(6'h0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      rdchk(HDR_WORD0_ADDR + 12'(4 * k), hword(hdr_req, k));
    end
    rdchk(CAP_CTRL_ADDR, ctrl_exp(p1, 0, 0));
    rdchk(INT_FLAGS_ADDR, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, INT_MASK_ADDR, 32'h2);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    hdr_req <= ~hdr_req;
    pos_req <= ~p1;
    pulse(6'h0, 1'b1);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, HDR_WORD0_ADDR, 32'h0);
    for (int k = 0; k < 4; k++) begin
      rdchk(HDR_WORD0_ADDR + 12'(4 * k), hword(hdr_req, k));
    end
    rdchk(CAP_CTRL_ADDR, ctrl_exp(p1, 0, 0));
    rdchk(INT_MASK_ADDR, 32'h0);
    rst <= 1'b1;
    cold <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    cold <= 1'b0;
    rdchk(HDR_WORD3_ADDR, 32'h0);
    rdchk(CAP_CTRL_ADDR, ctrl_exp(5'h0, 0, 0));
    print_verdict;
  end
endmodule
`default_nettype wire
